// ==== pkg/dsl_pkg.sv ====
// constants for the dual synthesizer latch decoder
package dsl_pkg;
	localparam int WORD_W = 22;
	localparam int R_W = 14;
	localparam int A_W = 6;
	localparam int B_W = 11;
	localparam int PM_W = 7;
	// latch select codes in the two lowest bits
	localparam logic [1:0] SEL_IF_R = 2'h0;
	localparam logic [1:0] SEL_IF_N = 2'h1;
	localparam logic [1:0] SEL_RF_R = 2'h2;
	localparam logic [1:0] SEL_RF_N = 2'h3;
	// reference latch fields
	localparam int R_LSB = 2;
	localparam int R_MSB = 15;
	localparam int POL_BIT = 16;
	localparam int HIZ_BIT = 17;
	localparam int CUR_BIT = 18;
	// n-divider latch fields
	localparam int A_LSB = 2;
	localparam int A_MSB = 7;
	localparam int B_LSB = 9;
	localparam int B_MSB = 19;
	localparam int PRE_BIT = 20;
	localparam int PD_BIT = 21;
	// prescaler modulus p of p/p+1
	localparam logic [PM_W-1:0] IF_P_LO = 7'h08;
	localparam logic [PM_W-1:0] IF_P_HI = 7'h10;
	localparam logic [PM_W-1:0] RF_P_LO = 7'h20;
	localparam logic [PM_W-1:0] RF_P_HI = 7'h40;
	localparam logic [R_W-1:0] R_RESET = 14'h0000;
	localparam logic [R_W-1:0] R_ONE = 14'h0001;
	localparam logic [B_W-1:0] B_ONE = 11'h001;
	localparam logic [A_W-1:0] A_ONE = 6'h01;
	localparam logic [PM_W-1:0] PM_ONE = 7'h01;
endpackage

// ==== pkg/dsl_ndiv_if.sv ====
// configuration and result of one n divider
`timescale 1ns/1ns
interface dsl_ndiv_if;
	logic [dsl_pkg::B_W-1:0] main_cnt;
	logic [dsl_pkg::A_W-1:0] swallow_cnt;
	logic [dsl_pkg::PM_W-1:0] modulus;
	logic vco_tick;
	logic div_pulse;
	modport cfg (output main_cnt, output swallow_cnt, output modulus, output vco_tick,
		input div_pulse);
	modport div (input main_cnt, input swallow_cnt, input modulus, input vco_tick,
		output div_pulse);
endinterface

// ==== hw/dsl_ndiv.sv ====
// n divider: swallow counter, main counter and dual-modulus prescaler
`timescale 1ns/1ns
module dsl_ndiv (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// configuration and output
	dsl_ndiv_if.div nd
);
	logic [dsl_pkg::PM_W-1:0] pres_q;
	logic [dsl_pkg::A_W-1:0] a_q;
	logic [dsl_pkg::B_W-1:0] b_q;
	logic [dsl_pkg::A_W-1:0] a_next;
	logic pulse_q;
	logic cyc_end;

	assign cyc_end = nd.vco_tick && (pres_q == '0);
	assign a_next = (a_q == '0) ? '0 : a_q - dsl_pkg::A_ONE;
	assign nd.div_pulse = pulse_q;

	// a prescaler cycle with swallow left runs p+1 ticks, else p ticks
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pres_q <= '0;
			a_q <= '0;
			b_q <= '0;
		end
		else if (cyc_end)
		begin
			if (b_q <= dsl_pkg::B_ONE)
			begin
				b_q <= nd.main_cnt;
				a_q <= nd.swallow_cnt;
				pres_q <= (nd.swallow_cnt != '0) ? nd.modulus : nd.modulus - dsl_pkg::PM_ONE;
			end
			else
			begin
				b_q <= b_q - dsl_pkg::B_ONE;
				a_q <= a_next;
				pres_q <= (a_next != '0) ? nd.modulus : nd.modulus - dsl_pkg::PM_ONE;
			end
		end
		else if (nd.vco_tick)
		begin
			pres_q <= pres_q - dsl_pkg::PM_ONE;
		end
	end

	// one pulse per b*p+a ticks, needs main count not below swallow count
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pulse_q <= 1'b0;
		else
			pulse_q <= cyc_end && (b_q <= dsl_pkg::B_ONE);
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_main_reload: assert property (cyc_end && b_q <= dsl_pkg::B_ONE |=>
		b_q == $past(nd.main_cnt) && a_q == $past(nd.swallow_cnt) && pulse_q)
		else $error("main counter not reloaded at terminal count");
	a_swallow_long: assert property (cyc_end && b_q > dsl_pkg::B_ONE && a_next != '0 |=>
		pres_q == $past(nd.modulus))
		else $error("swallow cycle did not use p+1");
	a_plain_short: assert property (cyc_end && b_q > dsl_pkg::B_ONE && a_next == '0 |=>
		pres_q == $past(nd.modulus) - dsl_pkg::PM_ONE)
		else $error("plain cycle did not use p");
endmodule

// ==== hw/dsl_latch_decode.sv ====
// serial input register, four programming latches and the divider chains
`timescale 1ns/1ns
//
// Contract
// - 22 bits shift on sclk rise, strobe latches
// - select 0,0 loads 14-bit IF reference divide
// - IF polarity bit sets detector sense
// - IF tristate bit floats IF charge pump
// - IF current bit picks 1.25 or 4.375 mA
// - select 0,1 loads IF N-divider latch
// - N divider: 6-bit swallow, 11-bit main counter
// - IF prescaler bit picks 8/9 or 16/17
// - select 1,0 loads 14-bit RF reference divide
// - RF polarity bit sets detector sense
// - RF N latch: DB21 powerdown, DB20 prescaler
// - select 1,1 loads RF N; 32/33 or 64/65
// - RF tristate bit floats RF charge pump
// - RF current bit picks 1.25 or 4.375 mA
module dsl_latch_decode (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// serial programming link
	input wire logic sclk_in,
	input wire logic serial_data_in,
	input wire logic latch_strobe,
	// divider input ticks
	input wire logic ref_tick,
	input wire logic if_vco_tick,
	input wire logic rf_vco_tick,
	// IF controls
	output logic [dsl_pkg::R_W-1:0] if_ref_div,
	output logic if_detector_polarity,
	output logic if_pump_tristate,
	output logic if_pump_current_sel,
	output logic if_prescaler_sel,
	output logic if_powerdown,
	// RF controls
	output logic [dsl_pkg::R_W-1:0] rf_ref_div,
	output logic rf_detector_polarity,
	output logic rf_pump_tristate,
	output logic rf_pump_current_sel,
	output logic rf_prescaler_sel,
	output logic rf_powerdown,
	// divided pulses to the phase detectors
	output logic if_ref_pulse,
	output logic rf_ref_pulse,
	output logic if_n_pulse,
	output logic rf_n_pulse
);
	logic [dsl_pkg::WORD_W-1:0] shift_q;
	logic sclk_q;
	logic strobe_q;
	logic sclk_rise;
	logic load;
	logic [dsl_pkg::B_W-1:0] if_main_q;
	logic [dsl_pkg::A_W-1:0] if_swallow_q;
	logic [dsl_pkg::B_W-1:0] rf_main_q;
	logic [dsl_pkg::A_W-1:0] rf_swallow_q;
	logic [dsl_pkg::R_W-1:0] rdiv [2];
	logic [1:0] rpulse_q;

	dsl_ndiv_if if_nd ();
	dsl_ndiv_if rf_nd ();

	assign sclk_rise = sclk_in && !sclk_q;
	assign load = latch_strobe && !strobe_q;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_q <= 1'b0;
			strobe_q <= 1'b0;
		end
		else
		begin
			sclk_q <= sclk_in;
			strobe_q <= latch_strobe;
		end
	end

	// msb first, so the select bits arrive last
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			shift_q <= '0;
		else if (sclk_rise)
			shift_q <= {shift_q[dsl_pkg::WORD_W-2:0], serial_data_in};
	end

	// IF reference latch
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			if_ref_div <= dsl_pkg::R_RESET;
			if_detector_polarity <= 1'b0;
			if_pump_tristate <= 1'b0;
			if_pump_current_sel <= 1'b0;
		end
		else if (load && shift_q[1:0] == dsl_pkg::SEL_IF_R)
		begin
			if_ref_div <= shift_q[dsl_pkg::R_MSB:dsl_pkg::R_LSB];
			if_detector_polarity <= shift_q[dsl_pkg::POL_BIT];
			if_pump_tristate <= shift_q[dsl_pkg::HIZ_BIT];
			if_pump_current_sel <= shift_q[dsl_pkg::CUR_BIT];
		end
	end

	// IF n-divider latch
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			if_main_q <= '0;
			if_swallow_q <= '0;
			if_prescaler_sel <= 1'b0;
			if_powerdown <= 1'b0;
		end
		else if (load && shift_q[1:0] == dsl_pkg::SEL_IF_N)
		begin
			if_main_q <= shift_q[dsl_pkg::B_MSB:dsl_pkg::B_LSB];
			if_swallow_q <= shift_q[dsl_pkg::A_MSB:dsl_pkg::A_LSB];
			if_prescaler_sel <= shift_q[dsl_pkg::PRE_BIT];
			if_powerdown <= shift_q[dsl_pkg::PD_BIT];
		end
	end

	// RF reference latch
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rf_ref_div <= dsl_pkg::R_RESET;
			rf_detector_polarity <= 1'b0;
			rf_pump_tristate <= 1'b0;
			rf_pump_current_sel <= 1'b0;
		end
		else if (load && shift_q[1:0] == dsl_pkg::SEL_RF_R)
		begin
			rf_ref_div <= shift_q[dsl_pkg::R_MSB:dsl_pkg::R_LSB];
			rf_detector_polarity <= shift_q[dsl_pkg::POL_BIT];
			rf_pump_tristate <= shift_q[dsl_pkg::HIZ_BIT];
			rf_pump_current_sel <= shift_q[dsl_pkg::CUR_BIT];
		end
	end

	// RF n-divider latch
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rf_main_q <= '0;
			rf_swallow_q <= '0;
			rf_prescaler_sel <= 1'b0;
			rf_powerdown <= 1'b0;
		end
		else if (load && shift_q[1:0] == dsl_pkg::SEL_RF_N)
		begin
			rf_main_q <= shift_q[dsl_pkg::B_MSB:dsl_pkg::B_LSB];
			rf_swallow_q <= shift_q[dsl_pkg::A_MSB:dsl_pkg::A_LSB];
			rf_prescaler_sel <= shift_q[dsl_pkg::PRE_BIT];
			rf_powerdown <= shift_q[dsl_pkg::PD_BIT];
		end
	end

	// reference dividers; a ratio of 0 or 1 passes every tick
	assign rdiv[0] = if_ref_div;
	assign rdiv[1] = rf_ref_div;
	generate
		for (genvar ch = 0; ch < 2; ch++)
		begin : g_rdiv
			logic [dsl_pkg::R_W-1:0] cnt_q;
			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
				begin
					cnt_q <= dsl_pkg::R_RESET;
					rpulse_q[ch] <= 1'b0;
				end
				else
				begin
					rpulse_q[ch] <= ref_tick && cnt_q <= dsl_pkg::R_ONE;
					if (ref_tick)
						cnt_q <= (cnt_q <= dsl_pkg::R_ONE) ? rdiv[ch] : cnt_q - dsl_pkg::R_ONE;
				end
			end
		end
	endgenerate
	assign if_ref_pulse = rpulse_q[0];
	assign rf_ref_pulse = rpulse_q[1];

	// new main and swallow counts take effect at the next main-counter reload, a new prescaler modulus at the next prescaler cycle
	assign if_nd.main_cnt = if_main_q;
	assign if_nd.swallow_cnt = if_swallow_q;
	assign if_nd.modulus = if_prescaler_sel ? dsl_pkg::IF_P_HI : dsl_pkg::IF_P_LO;
	assign if_nd.vco_tick = if_vco_tick && !if_powerdown;
	assign rf_nd.main_cnt = rf_main_q;
	assign rf_nd.swallow_cnt = rf_swallow_q;
	assign rf_nd.modulus = rf_prescaler_sel ? dsl_pkg::RF_P_HI : dsl_pkg::RF_P_LO;
	assign rf_nd.vco_tick = rf_vco_tick && !rf_powerdown;
	assign if_n_pulse = if_nd.div_pulse;
	assign rf_n_pulse = rf_nd.div_pulse;

	dsl_ndiv u_if_ndiv (.clock(clock), .rst_n(rst_n), .nd(if_nd.div));
	dsl_ndiv u_rf_ndiv (.clock(clock), .rst_n(rst_n), .nd(rf_nd.div));

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_shift_bit_in: assert property (sclk_rise |=> shift_q[0] == $past(serial_data_in) &&
		shift_q[dsl_pkg::WORD_W-1:1] == $past(shift_q[dsl_pkg::WORD_W-2:0]))
		else $error("serial bit not shifted in");
	a_no_load_hold: assert property (!load |=> $stable(if_ref_div) && $stable(rf_main_q))
		else $error("latch changed without strobe");
	a_if_ref_load: assert property (load && shift_q[1:0] == dsl_pkg::SEL_IF_R |=>
		if_ref_div == $past(shift_q[dsl_pkg::R_MSB:dsl_pkg::R_LSB]))
		else $error("IF reference divide not loaded");
	a_if_ref_bits: assert property (load && shift_q[1:0] == dsl_pkg::SEL_IF_R |=>
		{if_detector_polarity, if_pump_tristate, if_pump_current_sel} ==
		$past({shift_q[dsl_pkg::POL_BIT], shift_q[dsl_pkg::HIZ_BIT], shift_q[dsl_pkg::CUR_BIT]}))
		else $error("IF reference control bits not loaded");
	a_if_n_load: assert property (load && shift_q[1:0] == dsl_pkg::SEL_IF_N |=>
		if_main_q == $past(shift_q[dsl_pkg::B_MSB:dsl_pkg::B_LSB]) &&
		if_swallow_q == $past(shift_q[dsl_pkg::A_MSB:dsl_pkg::A_LSB]))
		else $error("IF n divider latch not loaded");
	a_if_modulus: assert property (load && shift_q[1:0] == dsl_pkg::SEL_IF_N |=>
		if_prescaler_sel == $past(shift_q[dsl_pkg::PRE_BIT]) &&
		if_nd.modulus == (if_prescaler_sel ? dsl_pkg::IF_P_HI : dsl_pkg::IF_P_LO))
		else $error("IF prescaler modulus wrong");
	a_rf_ref_load: assert property (load && shift_q[1:0] == dsl_pkg::SEL_RF_R |=>
		rf_ref_div == $past(shift_q[dsl_pkg::R_MSB:dsl_pkg::R_LSB]) &&
		rf_detector_polarity == $past(shift_q[dsl_pkg::POL_BIT]))
		else $error("RF reference latch not loaded");
	a_rf_pump_bits: assert property (load && shift_q[1:0] == dsl_pkg::SEL_RF_R |=>
		rf_pump_tristate == $past(shift_q[dsl_pkg::HIZ_BIT]) &&
		rf_pump_current_sel == $past(shift_q[dsl_pkg::CUR_BIT]))
		else $error("RF pump bits not loaded");
	a_rf_n_load: assert property (load && shift_q[1:0] == dsl_pkg::SEL_RF_N |=>
		rf_powerdown == $past(shift_q[dsl_pkg::PD_BIT]) &&
		rf_prescaler_sel == $past(shift_q[dsl_pkg::PRE_BIT]) && $stable(if_main_q))
		else $error("RF n divider latch not loaded");
	a_rf_pd_quiet: assert property (rf_powerdown |-> ##2 !rf_n_pulse)
		else $error("RF divider ran in power-down");
endmodule

// ==== verification/dsl_host_model.sv ====
// host controller model that shifts programming words into the decoder
`timescale 1ns/1ns
module dsl_host_model (
	// clock
	input wire logic clock,
	// serial programming link
	output logic sclk_in,
	output logic serial_data_in,
	output logic latch_strobe
);
	initial
	begin
		sclk_in = 1'b0;
		serial_data_in = 1'b0;
		latch_strobe = 1'b0;
	end
	// shifts the low n bits of w, msb first; slow stretches each serial clock phase
	task automatic send(input logic [31:0] w, input int n, input int slow);
		int i;
		for (i = n - 1; i >= 0; i--)
		begin
			@(posedge clock);
			#1;
			sclk_in = 1'b1;
			serial_data_in = w[i];
			repeat (1 + slow) @(posedge clock);
			#1;
			sclk_in = 1'b0;
			// released data line shows the inverse so a stale bit is never taken
			serial_data_in = ~w[i];
			repeat (slow) @(posedge clock);
		end
		@(posedge clock);
		#1;
		latch_strobe = 1'b1;
		@(posedge clock);
		#1;
		latch_strobe = 1'b0;
	endtask
endmodule

// ==== verification/dual_synth_latch_decode_bench.sv ====
// self-checking bench of the latch decoder against a behavioural model
`timescale 1ns/1ns
module dual_synth_latch_decode_bench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic ref_tick = 1'b0;
	logic if_vco_tick = 1'b0;
	logic rf_vco_tick = 1'b0;
	logic sclk_in, serial_data_in, latch_strobe;
	logic [13:0] if_ref_div, rf_ref_div;
	logic if_detector_polarity, if_pump_tristate, if_pump_current_sel, if_prescaler_sel;
	logic rf_detector_polarity, rf_pump_tristate, rf_pump_current_sel, rf_prescaler_sel;
	logic if_powerdown, rf_powerdown, if_ref_pulse, rf_ref_pulse, if_n_pulse, rf_n_pulse;
	logic [21:0] model_q [4];
	logic [21:0] last_w;
	int fails = 0;
	int checks = 0;
	int seed = 13546;
	int i;
	initial
	begin
		forever #20 clock = ~clock;
	end
	dsl_host_model i_host (.clock(clock), .sclk_in(sclk_in),
		.serial_data_in(serial_data_in), .latch_strobe(latch_strobe));
	dsl_latch_decode i_dut (.clock(clock), .rst_n(rst_n), .sclk_in(sclk_in),
		.serial_data_in(serial_data_in), .latch_strobe(latch_strobe), .ref_tick(ref_tick),
		.if_vco_tick(if_vco_tick), .rf_vco_tick(rf_vco_tick), .if_ref_div(if_ref_div),
		.if_detector_polarity(if_detector_polarity), .if_pump_tristate(if_pump_tristate),
		.if_pump_current_sel(if_pump_current_sel), .if_prescaler_sel(if_prescaler_sel),
		.if_powerdown(if_powerdown), .rf_ref_div(rf_ref_div),
		.rf_detector_polarity(rf_detector_polarity), .rf_pump_tristate(rf_pump_tristate),
		.rf_pump_current_sel(rf_pump_current_sel), .rf_prescaler_sel(rf_prescaler_sel),
		.rf_powerdown(rf_powerdown), .if_ref_pulse(if_ref_pulse), .rf_ref_pulse(rf_ref_pulse),
		.if_n_pulse(if_n_pulse), .rf_n_pulse(rf_n_pulse));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, want, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// update the model the way the select bits route it, shift the word, then compare
	task automatic write(input logic [31:0] w, input int n, input int slow);
		if (n > 0)
			last_w = w[21:0];
		model_q[last_w[1:0]] = last_w;
		i_host.send(w, n, slow);
		repeat (2) @(posedge clock);
		#1;
		check("if_ref_div", if_ref_div, model_q[0][15:2]);
		check("if_detector_polarity", if_detector_polarity, model_q[0][16]);
		check("if_pump_tristate", if_pump_tristate, model_q[0][17]);
		check("if_pump_current_sel", if_pump_current_sel, model_q[0][18]);
		check("if_prescaler_sel", if_prescaler_sel, model_q[1][20]);
		check("if_powerdown", if_powerdown, model_q[1][21]);
		check("rf_ref_div", rf_ref_div, model_q[2][15:2]);
		check("rf_detector_polarity", rf_detector_polarity, model_q[2][16]);
		check("rf_pump_tristate", rf_pump_tristate, model_q[2][17]);
		check("rf_pump_current_sel", rf_pump_current_sel, model_q[2][18]);
		check("rf_prescaler_sel", rf_prescaler_sel, model_q[3][20]);
		check("rf_powerdown", rf_powerdown, model_q[3][21]);
	endtask
	function automatic logic pulse_of(input int ch);
		case (ch)
			0: return if_ref_pulse;
			1: return rf_ref_pulse;
			2: return if_n_pulse;
			default: return rf_n_pulse;
		endcase
	endfunction
	// spacing of the second and third pulse, so any reload in flight has settled;
	// with fewer than three pulses in the window the number of pulses seen is compared
	task automatic gap(input int ch, input int want);
		int n, t, prev;
		n = 0;
		t = 0;
		prev = 0;
		while (n < 3 && t < 3000)
		begin
			@(posedge clock);
			#1;
			t++;
			if (pulse_of(ch) === 1'b1)
			begin
				n++;
				if (n == 2)
					prev = t;
			end
		end
		check("pulse gap", (n == 3) ? t - prev : n, want);
	endtask
	initial
	begin
		repeat (20000) @(posedge clock);
		fails++;
		conclude();
	end
	initial
	begin
		last_w = 22'h000000;
		for (i = 0; i < 4; i++)
			model_q[i] = 22'h000000;
		repeat (6) @(posedge clock);
		#1;
		rst_n = 1'b1;
		write(32'h0, 0, 0);
		$display("test reset done");
		for (i = 0; i < 12; i++)
			write({$random(seed)} & 32'h3ffffc | (i % 4), 22, $random(seed) & 1);
		$display("test random latches done");
		// extra leading bits fall out, only the last 22 count
		write(32'h2a5a5a5 & 32'h3ffffff, 26, 0);
		write(32'h0, 0, 0);
		$display("test overflow and bare strobe done");
		write({10'h000, 14'h0003, 2'h0}, 22, 0);
		write({10'h000, 14'h0005, 2'h2}, 22, 0);
		write({1'b0, 1'b0, 11'h002, 1'b0, 6'h01, 2'h1}, 22, 0);
		write({1'b0, 1'b1, 11'h001, 1'b0, 6'h01, 2'h3}, 22, 1);
		@(posedge clock);
		#1;
		ref_tick = 1'b1;
		if_vco_tick = 1'b1;
		rf_vco_tick = 1'b1;
		gap(0, 3);
		gap(1, 5);
		gap(2, 17);
		gap(3, 65);
		write({1'b0, 1'b1, 11'h002, 1'b0, 6'h01, 2'h1}, 22, 0);
		gap(2, 33);
		// power-down gates the rf ticks, so no pulse at all is expected
		write({1'b1, 1'b1, 11'h001, 1'b0, 6'h01, 2'h3}, 22, 0);
		gap(3, 0);
		$display("test dividers done");
		@(posedge clock);
		#1;
		rst_n = 1'b0;
		@(posedge clock);
		#1;
		rst_n = 1'b1;
		ref_tick = 1'b0;
		// reset clears the input register too, so a bare strobe loads zero into select 0
		last_w = 22'h000000;
		for (i = 0; i < 4; i++)
			model_q[i] = 22'h000000;
		write(32'h0, 0, 0);
		$display("test second reset done");
		conclude();
	end
endmodule
